// >>> rtl/cbh_pkg.sv
package cbh_pkg;

  // ----------------------------------------------------------------
  // Configuration space layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  HDR_TYPE_OFS     = 8'h0e;
  localparam logic [7:0]  SELF_TEST_OFS    = 8'h0f;
  localparam logic [7:0]  WIN_BASE_OFS     = 8'h10;
  localparam logic [7:0]  CAP_PTR_OFS      = 8'h14;
  localparam logic [7:0]  CARD_STAT_OFS    = 8'h16;
  localparam logic [7:0]  STD_HDR_LAST     = 8'h7f;
  localparam logic [7:0]  EXT_FIRST        = 8'h80;
  localparam logic [7:0]  PM_BLOCK_OFS     = 8'ha0;
  localparam logic [7:0]  PM_BLOCK_NEXT    = 8'ha4;

  // ----------------------------------------------------------------
  // Fixed and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  HDR_TYPE_VAL     = 8'h82;
  localparam logic [7:0]  SELF_TEST_VAL    = 8'h00;
  localparam logic [7:0]  CAP_PTR_VAL      = 8'ha0;
  localparam logic [15:0] CARD_STAT_RST    = 16'h0200;
  localparam logic [19:0] WIN_BASE_RST     = 20'h00000;
  localparam logic [1:0]  SEL_TIMING_VAL   = 2'b01;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int WIN_LSB                   = 12;
  localparam int WIN_COMPAT_BIT            = 11;
  localparam int ST_PARITY_BIT             = 15;
  localparam int ST_SERR_BIT               = 14;
  localparam int ST_MABORT_BIT             = 13;
  localparam int ST_TA_RCVD_BIT            = 12;
  localparam int ST_TA_SENT_BIT            = 11;
  localparam int ST_TIMING_LSB             = 9;
  localparam int ST_DPAR_BIT               = 8;
  localparam int NUM_FUNC                  = 2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        func;
    logic [5:0]  dw;
    logic        wr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cbh_cfg_req_t;

  typedef struct packed {
    logic addr_par_err;
    logic data_par_err;
    logic serr_from_card;
    logic master_abort;
    logic tabort_rcvd;
    logic tabort_sent;
    logic perr_line;
    logic bridge_is_master;
    logic perr_resp_en;
  } cbh_card_evt_t;

endpackage : cbh_pkg

// >>> rtl/cbh_cfg_regs.sv
// Operation
// - Header type byte always reads 82h, multifunction bridge layout.
// - Offsets 0-7Fh standard header; 80h-FFh reserved extension space.
// - Self-test byte reads 00h in both functions.
// - Window base bits 31-12 read/write, bits 11-0 read zero.
// - All-ones write reads back FFFF F000h, sizing a 4K window.
// - Socket registers decode at window offset 000h, compat set 800h.
// - Each function holds its own independent window base.
// - Capability pointer reads A0h; power block at A0h and A4h.
// - Status flags clear on write of one; zero leaves them alone.
// - Bit 15 set on card address or data parity error.
// - Bit 14 set on card system error; bridge never drives it.
// - Bit 13 set when bridge-initiated cycle ends in master abort.
// - Bit 12 set when card target-aborts a bridge-initiated cycle.
// - Bit 11 set when bridge as target ends with target abort.
// - Bits 10-9 hardwired 01b, medium device-select timing.
// - Bit 8 set on parity line, bridge master and response enabled.
// - Bits 7-5 and 4-0 read zero.
// - Card clock at most 33 MHz; fast-clock capability bit zero.
// - Status resets to 0200h, one copy per function.
`timescale 1ns/100ps

module cbh_cfg_regs
  import cbh_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // Configuration port
  input  wire logic                 cfg_valid,
  input  wire cbh_cfg_req_t         cfg_req,
  output logic                      cfg_ack,
  output logic [31:0]               cfg_rdata,
  // Card-side events, one set per function
  input  wire cbh_card_evt_t [1:0]  card_evt,
  // Memory window decode
  input  wire logic                 mem_valid,
  input  wire logic [31:0]          mem_addr,
  output logic [1:0]                socket_hit,
  output logic [1:0]                compat_hit,
  // Card system error pin
  output logic                      card_system_error_line_o,
  output logic                      card_system_error_line_oe_n
);

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic        wr_now;
  logic        rd_now;
  logic [5:0]  dw_hdr;
  logic [5:0]  dw_base;
  logic [5:0]  dw_cap;
  logic [5:0]  dw_pm0;
  logic [5:0]  dw_pm1;
  logic [5:0]  dw_ext;
  logic        is_hdr;
  logic        is_base;
  logic        is_stat;
  logic        is_pm;
  logic        is_ext;

  // Dword indices from the byte offsets
  assign dw_hdr  = HDR_TYPE_OFS[7:2];
  assign dw_base = WIN_BASE_OFS[7:2];
  assign dw_cap  = CAP_PTR_OFS[7:2];
  assign dw_pm0  = PM_BLOCK_OFS[7:2];
  assign dw_pm1  = PM_BLOCK_NEXT[7:2];
  assign dw_ext  = EXT_FIRST[7:2];
  assign wr_now  = cfg_valid & cfg_req.wr;
  assign rd_now  = cfg_valid & ~cfg_req.wr;

  // ----------------------------------------------------------------
  // Offset classes
  // ----------------------------------------------------------------
  // Status shares its dword with the capability pointer
  assign is_hdr  = (cfg_req.dw == dw_hdr);
  assign is_base = (cfg_req.dw == dw_base);
  assign is_stat = (cfg_req.dw == dw_cap);
  assign is_pm   = (cfg_req.dw == dw_pm0) | (cfg_req.dw == dw_pm1);
  assign is_ext  = (cfg_req.dw >= dw_ext);

  // ----------------------------------------------------------------
  // Per-function state
  // ----------------------------------------------------------------
  logic [19:0] win_base_r [NUM_FUNC];
  logic [15:0] card_stat_r [NUM_FUNC];
  logic [15:0] card_stat_nxt [NUM_FUNC];
  logic [31:0] base_word [NUM_FUNC];
  logic [31:0] stat_word [NUM_FUNC];

  genvar f;
  generate
    for (f = 0; f < NUM_FUNC; f++) begin : g_func
      localparam logic FID = 1'(f);

      logic        fn_sel;
      logic        sel_base;
      logic        sel_stat;
      logic        base_set;
      logic        in_win;
      logic        ev_parity;
      logic        ev_serr;
      logic        ev_mabort;
      logic        ev_ta_rcvd;
      logic        ev_ta_sent;
      logic        ev_dpar;
      logic [15:0] wr1_v;
      logic [15:0] set_v;
      logic [15:0] clr_v;

      // ------------------------------------------------------------
      // Write strobes
      // ------------------------------------------------------------
      assign fn_sel   = (cfg_req.func == FID);
      assign sel_base = wr_now & fn_sel & is_base;
      // Pointer byte is read-only, only status bytes act
      assign sel_stat = wr_now & fn_sel & is_stat;
      assign wr1_v    = cfg_req.wdata[31:16];

      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          win_base_r[f] <= WIN_BASE_RST;
        end else if (sel_base) begin
          if (cfg_req.be[1]) begin
            win_base_r[f][3:0] <= cfg_req.wdata[15:12];
          end
          if (cfg_req.be[2]) begin
            win_base_r[f][11:4] <= cfg_req.wdata[23:16];
          end
          if (cfg_req.be[3]) begin
            win_base_r[f][19:12] <= cfg_req.wdata[31:24];
          end
        end
      end

      // ------------------------------------------------------------
      // Card-side events
      // ------------------------------------------------------------
      // Address or data parity
      assign ev_parity  = card_evt[f].addr_par_err
                          | card_evt[f].data_par_err;
      assign ev_serr    = card_evt[f].serr_from_card;
      assign ev_mabort  = card_evt[f].master_abort;
      assign ev_ta_rcvd = card_evt[f].tabort_rcvd;
      assign ev_ta_sent = card_evt[f].tabort_sent;
      // All three conditions in one cycle
      assign ev_dpar    = card_evt[f].perr_line
                          & card_evt[f].bridge_is_master
                          & card_evt[f].perr_resp_en;

      // Hardware events
      always_comb begin
        set_v = 16'h0000;
        set_v[ST_PARITY_BIT]  = ev_parity;
        set_v[ST_SERR_BIT]    = ev_serr;
        set_v[ST_MABORT_BIT]  = ev_mabort;
        set_v[ST_TA_RCVD_BIT] = ev_ta_rcvd;
        set_v[ST_TA_SENT_BIT] = ev_ta_sent;
        set_v[ST_DPAR_BIT]    = ev_dpar;
      end

      always_comb begin
        clr_v = 16'h0000;
        if (sel_stat && cfg_req.be[3]) begin
          clr_v[ST_PARITY_BIT]  = wr1_v[ST_PARITY_BIT];
          clr_v[ST_SERR_BIT]    = wr1_v[ST_SERR_BIT];
          clr_v[ST_MABORT_BIT]  = wr1_v[ST_MABORT_BIT];
          clr_v[ST_TA_RCVD_BIT] = wr1_v[ST_TA_RCVD_BIT];
          clr_v[ST_TA_SENT_BIT] = wr1_v[ST_TA_SENT_BIT];
          clr_v[ST_DPAR_BIT]    = wr1_v[ST_DPAR_BIT];
        end
      end

      // Set wins so no event is lost in a clear cycle
      always_comb begin
        card_stat_nxt[f] = (card_stat_r[f] & ~clr_v) | set_v;
        card_stat_nxt[f][10:9] = SEL_TIMING_VAL;
        card_stat_nxt[f][7:0] = 8'h00;
      end

      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          card_stat_r[f] <= CARD_STAT_RST;
        end else begin
          card_stat_r[f] <= card_stat_nxt[f];
        end
      end

      // ------------------------------------------------------------
      // Window decode
      // ------------------------------------------------------------
      // Base of zero counts as unmapped, as after reset
      assign base_set = (win_base_r[f] != 20'h00000);
      assign in_win   = mem_valid & base_set
                        & (mem_addr[31:WIN_LSB] == win_base_r[f]);

      // Low half socket, upper half compat set
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          socket_hit[f] <= 1'b0;
          compat_hit[f] <= 1'b0;
        end else begin
          socket_hit[f] <= in_win & ~mem_addr[WIN_COMPAT_BIT];
          compat_hit[f] <= in_win & mem_addr[WIN_COMPAT_BIT];
        end
      end

      // ------------------------------------------------------------
      // Read words
      // ------------------------------------------------------------
      // Low twelve bits zero
      assign base_word[f] = {win_base_r[f], 12'h000};
      // Pointer in byte 0, status in bytes 3-2
      assign stat_word[f] = {card_stat_r[f], 8'h00, CAP_PTR_VAL};
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rd_nxt;
  logic [31:0] hdr_word;

  assign hdr_word = {SELF_TEST_VAL, HDR_TYPE_VAL, 16'h0000};

  // Extension and uncovered offsets read zero
  always_comb begin
    rd_nxt = 32'h00000000;
    if (is_pm) begin
      // Power block lives in its own unit
      rd_nxt = 32'h00000000;
    end else if (is_ext) begin
      rd_nxt = 32'h00000000;
    end else if (is_hdr) begin
      rd_nxt = hdr_word;
    end else if (is_base) begin
      rd_nxt = base_word[cfg_req.func];
    end else if (is_stat) begin
      rd_nxt = stat_word[cfg_req.func];
    end else begin
      rd_nxt = 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Answer
  // ----------------------------------------------------------------
  // Every access answered, read-only writes dropped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= cfg_valid;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_rdata <= 32'h00000000;
    end else if (rd_now) begin
      cfg_rdata <= rd_nxt;
    end else begin
      cfg_rdata <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Card system error pin
  // ----------------------------------------------------------------
  // Never driven by the bridge
  assign card_system_error_line_o    = 1'b0;
  assign card_system_error_line_oe_n = 1'b1;

endmodule : cbh_cfg_regs

// >>> verification/cbh_cfg_regs_asserts.sv
`timescale 1ns/100ps
// ----------------------------------------
// Config header checker
// ----------------------------------------
module cbh_cfg_regs_asserts
  import cbh_pkg::*;
(
  // Clock and reset
  input wire logic                clk,
  input wire logic                nrst,
  // Config port
  input wire logic                cfg_valid,
  input wire cbh_cfg_req_t        cfg_req,
  input wire logic                cfg_ack,
  input wire logic [31:0]         cfg_rdata,
  // Card side
  input wire cbh_card_evt_t [1:0] card_evt,
  input wire logic                card_system_error_line_o,
  input wire logic                card_system_error_line_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic rd_req;
  assign rd_req = cfg_valid && !cfg_req.wr;

  AST_ACK_ONE: assert property (cfg_valid |=> cfg_ack)
    else $error("access not acked");
  AST_HDR_DW: assert property (rd_req && cfg_req.dw == 6'h03 |=>
    cfg_rdata == 32'h0082_0000) else $error("header dword wrong");
  AST_CAP_PTR: assert property (rd_req && cfg_req.dw == 6'h05 |=>
    cfg_rdata[15:0] == 16'h00a0) else $error("cap pointer wrong");
  AST_SEL_TIM: assert property (rd_req && cfg_req.dw == 6'h05 |=>
    cfg_rdata[26:25] == 2'b01) else $error("select timing wrong");
  AST_ST_ZERO: assert property (rd_req && cfg_req.dw == 6'h05 |=>
    cfg_rdata[23:16] == 8'h00) else $error("status low byte set");
  AST_BASE_LO: assert property (rd_req && cfg_req.dw == 6'h04 |=>
    cfg_rdata[11:0] == 12'h000) else $error("base low bits set");
  AST_EXT_ZERO: assert property (rd_req && cfg_req.dw[5] |=>
    cfg_rdata == 32'h0) else $error("extension space not zero");
  AST_NO_SERR: assert property (card_system_error_line_oe_n &&
    !card_system_error_line_o) else $error("error line driven");
  AST_PAR_SET: assert property (card_evt[0].addr_par_err ##1
    (rd_req && cfg_req.dw == 6'h05 && !cfg_req.func) |=> cfg_rdata[31])
    else $error("parity flag missing");
  cover property (rd_req && cfg_req.dw == 6'h05);
  cover property (cfg_valid && cfg_req.wr && cfg_req.dw == 6'h04);
  cover property (card_evt[1].serr_from_card);
endmodule : cbh_cfg_regs_asserts

// >>> verification/cbh_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Host issuing config cycles
// ----------------------------------------
module cbh_host_model
  import cbh_pkg::*;
(
  // Clock
  input wire logic         clk,
  // Config port
  output cbh_cfg_req_t     cfg_req,
  output logic             cfg_valid,
  input wire logic         cfg_ack,
  input wire logic [31:0]  cfg_rdata
);
  initial begin
    cfg_valid = 1'b0;
    cfg_req   = '0;
  end
  // Called just after an edge; data inverted once released
  task automatic xfer(input logic f, input logic [5:0] d, input logic w,
    input logic [3:0] b, input logic [31:0] wd,
    output logic [31:0] rd, output logic ok);
    int n;
    cfg_valid <= 1'b1;
    cfg_req   <= '{f, d, w, b, wd};
    @(posedge clk);
    cfg_valid <= 1'b0;
    cfg_req   <= '{f, d, w, b, ~wd};
    ok = 1'b0;
    for (n = 0; n < 4 && ok !== 1'b1; n++) begin
      @(posedge clk);
      ok = cfg_ack;
    end
    rd = cfg_rdata;
  endtask : xfer
endmodule : cbh_host_model

// >>> verification/testbench.sv
`timescale 1ns/100ps
// ----------------------------------------
// Bench top
// ----------------------------------------
module testbench;
  import cbh_pkg::*;
  logic                clk, nrst, cfg_valid, cfg_ack, mem_valid, ok;
  logic                err_o, err_oe_n;
  cbh_cfg_req_t        cfg_req;
  cbh_card_evt_t [1:0] card_evt;
  logic [31:0]         cfg_rdata, mem_addr, rd;
  logic [1:0]          socket_hit, compat_hit;
  logic [15:0]         exp;
  int                  err_total, n_compared, i, f;
  logic [8:0] evt_tab [8] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010,
                              9'h008, 9'h007, 9'h006};
  int         bit_tab [8] = '{15, 15, 14, 13, 12, 11, 8, -1};

  cbh_cfg_regs u_dut (.clk, .nrst, .cfg_valid, .cfg_req, .cfg_ack,
    .cfg_rdata, .card_evt, .mem_valid, .mem_addr, .socket_hit,
    .compat_hit, .card_system_error_line_o(err_o),
    .card_system_error_line_oe_n(err_oe_n));
  cbh_host_model u_host (.clk, .cfg_req, .cfg_valid, .cfg_ack, .cfg_rdata);

  task automatic chk(input logic [31:0] got, e, input string m);
    n_compared++;
    if (got !== e) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, e);
    end
  endtask : chk
  task automatic acc(input logic fn, input logic [5:0] d, input logic w,
    input logic [3:0] b, input logic [31:0] wd);
    u_host.xfer(fn, d, w, b, wd, rd, ok);
    chk({31'h0, ok}, 32'h1, "ack");
  endtask : acc
  task automatic rchk(input logic fn, input logic [5:0] d,
    input logic [31:0] e, input string m);
    acc(fn, d, 1'b0, 4'h0, 32'h0);
    chk(rd, e, m);
  endtask : rchk
  task automatic mem(input logic [31:0] a, input logic [1:0] s, c);
    mem_valid <= 1'b1;
    mem_addr  <= a;
    @(posedge clk);
    mem_valid <= 1'b0;
    @(negedge clk);
    chk({30'h0, socket_hit}, {30'h0, s}, "socket hit");
    chk({30'h0, compat_hit}, {30'h0, c}, "compat hit");
    @(posedge clk);
  endtask : mem
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    $display("[FAIL] %0t watchdog", $time);
    stop_test;
  end
  initial begin
    nrst      = 1'b0;
    mem_valid = 1'b0;
    mem_addr  = 32'h0;
    card_evt  = '0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (f = 0; f < 2; f++) begin
      rchk(f[0], 6'h03, 32'h0082_0000, "header");
      rchk(f[0], 6'h04, 32'h0, "base reset");
      rchk(f[0], 6'h05, 32'h0200_00a0, "status reset");
    end
    chk({30'h0, err_o, err_oe_n}, 32'h1, "error line");
    $display("reset values done");
    acc(1'b0, 6'h04, 1'b1, 4'hf, 32'hffff_ffff);
    rchk(1'b0, 6'h04, 32'hffff_f000, "sizing");
    rchk(1'b1, 6'h04, 32'h0, "other base");
    acc(1'b0, 6'h03, 1'b1, 4'hf, 32'hffff_ffff);
    acc(1'b0, 6'h05, 1'b1, 4'h7, 32'hffff_ffff);
    rchk(1'b0, 6'h03, 32'h0082_0000, "ro header");
    rchk(1'b0, 6'h05, 32'h0200_00a0, "ro status");
    rchk(1'b0, 6'h28, 32'h0, "pm dword");
    rchk(1'b1, 6'h3f, 32'h0, "ext space");
    $display("base and read-only done");
    acc(1'b1, 6'h04, 1'b1, 4'he, 32'h1234_5fff);
    rchk(1'b1, 6'h04, 32'h1234_5000, "base low");
    mem(32'hffff_f004, 2'b01, 2'b00);
    mem(32'h1234_5804, 2'b00, 2'b10);
    $display("window decode done");
    for (i = 0; i < 8; i++) begin
      f = i % 2;
      card_evt[f] <= evt_tab[i];
      @(posedge clk);
      card_evt[f] <= '0;
      exp = 16'h0200;
      if (bit_tab[i] >= 0) begin
        exp = exp | (16'h1 << bit_tab[i]);
      end
      rchk(f[0], 6'h05, {exp, 16'h00a0}, "flag set");
      rchk(!f[0], 6'h05, 32'h0200_00a0, "other copy");
      acc(f[0], 6'h05, 1'b1, 4'h8, 32'h0);
      rchk(f[0], 6'h05, {exp, 16'h00a0}, "zero write");
      acc(f[0], 6'h05, 1'b1, 4'hc, 32'hffff_ffff);
      rchk(f[0], 6'h05, 32'h0200_00a0, "one clears");
    end
    $display("status flags done");
    stop_test;
  end
endmodule : testbench

bind cbh_cfg_regs cbh_cfg_regs_asserts u_chk (.clk, .nrst, .cfg_valid,
  .cfg_req, .cfg_ack, .cfg_rdata, .card_evt, .card_system_error_line_o,
  .card_system_error_line_oe_n);
